/* File: src/timer_mode_defs.vh */
// Constants for the timer mode control block
// ****************************************
// Function
// - With the counter select bit at 0 the count advances on every system clock.
// - With the counter select bit at 1 the count advances on each falling edge of the event count pin.
// - With the capture/reload select bit at 1 a trigger pin falling edge captures rather than reloads.
// - With capture/reload select at 0 the count reloads on overflow, and with no baud select on a trigger fall when trigger enable is 1.
// - With either baud select set the capture/reload select is ignored and overflow always reloads.
// - In auto-reload mode each overflow sets the overflow flag and loads the count from the reload pair.
// - In capture mode overflow sets the flag, and with trigger enable a trigger fall copies the count to the reload pair.
// - With a baud select set and run on, overflow pulses go to the serial port as its baud tick.
// - The mode comes from baud selects, capture/reload select and run; run at 0 stops the timer.
// ****************************************
`ifndef TIMER_MODE_DEFS_VH
`define TIMER_MODE_DEFS_VH
`define ADDR_CONTROL        4'h0
`define ADDR_COUNT_LOW      4'h1
`define ADDR_COUNT_HIGH     4'h2
`define ADDR_RELOAD_LOW     4'h3
`define ADDR_RELOAD_HIGH    4'h4
`define BIT_RUN             2
`define BIT_COUNTER_SEL     1
`define BIT_CAPTURE_SEL     0
`define BIT_TRIGGER_EN      3
`define BIT_TX_BAUD         4
`define BIT_RX_BAUD         5
`define BIT_TRIGGER_FLAG    6
`define BIT_OVERFLOW_FLAG   7
`define CONTROL_RESET       8'h00
`define COUNT_RESET         16'h0000
`define RELOAD_RESET        16'h0000
`endif

/* File: src/pin_edge_sync.v */
// Two-stage synchroniser with falling edge detect
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire clk,
  input  wire resetn,
  input  wire pinIn,
  output reg  fallPulse
);
  reg stageA;
  reg stageB;
  reg stageC;
  // Only stageB and stageC feed the edge detect; stageA is metastability guard
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stageA    <= 1'b1;
      stageB    <= 1'b1;
      stageC    <= 1'b1;
      fallPulse <= 1'b0;
    end else begin
      stageA    <= pinIn;
      stageB    <= stageA;
      stageC    <= stageB;
      fallPulse <= stageC & ~stageB;
    end
  end
endmodule // pin_edge_sync

/* File: src/timer_mode_control.v */
// Sixteen-bit timer with auto-reload, capture and baud generator modes
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "timer_mode_defs.vh"
module timer_mode_control (
  input  wire        clk,
  input  wire        resetn,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  input  wire        eventCountPin,
  input  wire        triggerInputPin,
  output reg         baudTick,
  output reg         overflowFlag
);
  // ****************************************
  // Mode decode
  // ****************************************
  localparam [3:0] MODE_STOP    = 4'b0001;
  localparam [3:0] MODE_RELOAD  = 4'b0010;
  localparam [3:0] MODE_CAPTURE = 4'b0100;
  localparam [3:0] MODE_BAUD    = 4'b1000;

  function [3:0] decodeMode;
    input run;
    input baud;
    input capSel;
    begin
      if (!run)
        decodeMode = MODE_STOP;
      else if (baud)
        decodeMode = MODE_BAUD;
      else if (capSel)
        decodeMode = MODE_CAPTURE;
      else
        decodeMode = MODE_RELOAD;
    end
  endfunction

  function [7:0] mergeByte;
    input [7:0] oldVal;
    input [7:0] newVal;
    input       laneEn;
    begin
      mergeByte = laneEn ? newVal : oldVal;
    end
  endfunction

  reg  [7:0]  control_reg;
  reg  [15:0] count_reg;
  reg  [15:0] reload_reg;
  reg  [15:0] count_next;
  reg  [15:0] reload_next;
  wire        eventFall;
  wire        triggerFall;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pin_edge_sync eventSync (
    .clk       (clk),
    .resetn    (resetn),
    .pinIn     (eventCountPin),
    .fallPulse (eventFall)
  );

  pin_edge_sync triggerSync (
    .clk       (clk),
    .resetn    (resetn),
    .pinIn     (triggerInputPin),
    .fallPulse (triggerFall)
  );

  wire        runControl  = control_reg[`BIT_RUN];
  wire        counterSel  = control_reg[`BIT_COUNTER_SEL];
  wire        captureSel  = control_reg[`BIT_CAPTURE_SEL];
  wire        trigEnable  = control_reg[`BIT_TRIGGER_EN];
  wire        baudSel     = control_reg[`BIT_TX_BAUD] | control_reg[`BIT_RX_BAUD];
  wire [3:0]  mode        = decodeMode(runControl, baudSel, captureSel);

  // ****************************************
  // Count step and events
  // ****************************************
  wire        stepEn      = (mode != MODE_STOP) & (counterSel ? eventFall : 1'b1);
  wire        overflow    = stepEn & (count_reg == 16'hFFFF);
  wire        trigUsed    = trigEnable & triggerFall & (mode != MODE_STOP);
  wire        trigReload  = trigUsed & (mode == MODE_RELOAD);
  wire        trigCapture = trigUsed & (mode == MODE_CAPTURE);

  // Bus access decode
  wire        busReq      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [3:0]  regIndex    = wb_adr_i[5:2];
  wire        mapped      = (wb_adr_i[31:6] == 26'h000_0000) & (regIndex <= `ADDR_RELOAD_HIGH);
  // Unmapped writes would otherwise alias onto the low registers through regIndex
  wire        busWrite    = busReq & wb_we_i & wb_sel_i[0] & mapped;

  always @* begin
    count_next  = count_reg;
    reload_next = reload_reg;
    if (stepEn)
      count_next = count_reg + 16'h0001;
    // Baud mode forces reload on overflow whatever the capture select says
    if (overflow && (mode != MODE_CAPTURE))
      count_next = reload_reg;
    if (trigReload)
      count_next = reload_reg;
    if (trigCapture)
      reload_next = count_reg;
    // Software writes last: they win over a same-cycle hardware update of the count
    if (busWrite && regIndex == `ADDR_COUNT_LOW)
      count_next[7:0] = wb_dat_i[7:0];
    if (busWrite && regIndex == `ADDR_COUNT_HIGH)
      count_next[15:8] = wb_dat_i[7:0];
    if (busWrite && regIndex == `ADDR_RELOAD_LOW)
      reload_next[7:0] = wb_dat_i[7:0];
    if (busWrite && regIndex == `ADDR_RELOAD_HIGH)
      reload_next[15:8] = wb_dat_i[7:0];
  end

  // ****************************************
  // Registers and flags
  // ****************************************
  reg [7:0] control_next;
  always @* begin
    control_next = control_reg;
    if (busWrite && regIndex == `ADDR_CONTROL)
      control_next = mergeByte(control_reg, wb_dat_i[7:0], 1'b1);
    // Hardware set wins over a same-cycle software clear
    if (overflow && (mode != MODE_BAUD))
      control_next[`BIT_OVERFLOW_FLAG] = 1'b1;
    if (trigUsed)
      control_next[`BIT_TRIGGER_FLAG] = 1'b1;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      control_reg  <= `CONTROL_RESET;
      count_reg    <= `COUNT_RESET;
      reload_reg   <= `RELOAD_RESET;
      baudTick     <= 1'b0;
      overflowFlag <= 1'b0;
    end else begin
      control_reg  <= control_next;
      count_reg    <= count_next;
      reload_reg   <= reload_next;
      baudTick     <= overflow & (mode == MODE_BAUD);
      overflowFlag <= control_next[`BIT_OVERFLOW_FLAG];
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Every access, mapped or not, is answered one cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= 32'h0000_0000;
      if (busReq && !wb_we_i && mapped) begin
        case (regIndex)
          `ADDR_CONTROL:     wb_dat_o <= {24'h00_0000, control_reg};
          `ADDR_COUNT_LOW:   wb_dat_o <= {24'h00_0000, count_reg[7:0]};
          `ADDR_COUNT_HIGH:  wb_dat_o <= {24'h00_0000, count_reg[15:8]};
          `ADDR_RELOAD_LOW:  wb_dat_o <= {24'h00_0000, reload_reg[7:0]};
          `ADDR_RELOAD_HIGH: wb_dat_o <= {24'h00_0000, reload_reg[15:8]};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // timer_mode_control

/* File: tb/timer_mode_control_checker.sv */
// Port checker for the timer mode block
`timescale 1ns/1ps
module timer_mode_control_checker (
  input wire        clk,
  input wire        resetn,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_we_i,
  input wire [3:0]  wb_sel_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        baudTick,
  input wire        overflowFlag
);
  // ****
  // Properties
  // ****
  wire take  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire clear = take & wb_we_i & wb_sel_i[0] & (wb_adr_i[31:2] == 30'h0000_0000) & ~wb_dat_i[7];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ack_follows: assert property (take |=> wb_ack_o) else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper bits set");
  a_write_quiet: assert property (take & wb_we_i |=> wb_dat_o == 32'h0000_0000) else $error("data on write");
  a_unmapped_zero: assert property (take & (wb_adr_i[31:6] != 26'h000_0000) |=> wb_dat_o == 32'h0000_0000)
    else $error("data from unmapped place");
  a_flag_holds: assert property (overflowFlag & ~clear |=> overflowFlag)
    else $error("flag dropped without clear");
  a_tick_no_flag: assert property ($rose(overflowFlag) |-> !baudTick)
    else $error("flag set in baud mode");
endmodule // timer_mode_control_checker

bind timer_mode_control timer_mode_control_checker chk (.clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
  .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .baudTick, .overflowFlag);

/* File: tb/timer_mode_pins.sv */
// Model of the count and trigger pins and of the serial port tick input
`timescale 1ns/1ps
module timer_mode_pins (
  input wire  clk,
  input wire  baudTick,
  output reg  eventCountPin,
  output reg  triggerInputPin,
  output int  ticks
);
  // ****
  // Pins idle high
  // ****
  initial begin
    eventCountPin = 1'b1;
    triggerInputPin = 1'b1;
    ticks = 0;
  end
  always @(posedge clk) if (baudTick === 1'b1) ticks <= ticks + 1;
  // Held low and high four clocks each so the two-stage sync cannot miss a fall
  task automatic strike(input bit trig, input int n);
    repeat (n) begin
      if (trig) triggerInputPin <= 1'b0;
      else eventCountPin <= 1'b0;
      repeat (4) @(posedge clk);
      triggerInputPin <= 1'b1;
      eventCountPin <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // timer_mode_pins

/* File: tb/timer_mode_control_tb_top.sv */
// Testbench of the timer mode block
`timescale 1ns/1ps
module timer_mode_control_tb_top;
  logic        clk, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, eventCountPin, triggerInputPin;
  logic        baudTick, overflowFlag;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [7:0]  expQ[$], e, hi;
  int          mismatches, n_tests, cycles, ticks, t0, n;
  timer_mode_control dut (.clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .eventCountPin, .triggerInputPin, .baudTick, .overflowFlag);
  timer_mode_pins pins (.clk, .baudTick, .eventCountPin, .triggerInputPin, .ticks);
  // ****
  // Clock, checks and bus
  // ****
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge clk) if (wb_ack_o === 1'b1) begin
    e = expQ.size() ? expQ.pop_front() : 8'hxx;
    check("read data", {8'h00, e}, wb_dat_o[15:0]);
  end
  task bus(input logic [31:0] adr, input logic we, input logic [7:0] d, input logic [7:0] exp);
    int k;
    expQ.push_back(we ? 8'h00 : exp);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= {24'h00_0000, d};
    wb_sel_i <= 4'h1 | 4'($urandom);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    k = 0;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && k++ < 20) @(posedge clk);
    check("bus ack", 16'h0001, 16'(wb_ack_o));
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input int idx, input logic [7:0] d);
    bus(32'(idx * 4), 1'b1, d, 8'h00);
  endtask
  task waitHigh(input bit tick);
    int k;
    k = 0;
    while ((tick ? baudTick : overflowFlag) !== 1'b1 && k++ < 60) @(posedge clk);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cycles == 20000) begin
    mismatches++;
    wrap_up();
  end
  initial begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    void'($urandom(32'h5427_f06e));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) bus(32'(i * 4), 1'b0, 8'h00, 8'h00);
    bus(32'h0000_0100, 1'b0, 8'h00, 8'h00);
    bus(32'h0000_0100, 1'b1, 8'h04, 8'h00);
    bus(32'h0000_0000, 1'b0, 8'h00, 8'h00);
    $display("reset values done");
    hi = 8'($urandom);
    wr(3, 8'h00); wr(4, hi); wr(1, 8'hf0); wr(2, 8'hff);
    wr(0, 8'h04);
    waitHigh(1'b0);
    check("overflow flag", 16'h0001, 16'(overflowFlag));
    bus(32'h0000_0008, 1'b0, 8'h00, hi);
    check("flag held", 16'h0001, 16'(overflowFlag));
    wr(0, 8'h00);
    bus(32'h0000_0000, 1'b0, 8'h00, 8'h00);
    $display("auto reload done");
    for (int c = 0; c < 2; c++) begin
      hi = 8'($urandom) | 8'h01;
      wr(3, 8'h00); wr(4, c ? 8'h00 : hi); wr(1, 8'h00); wr(2, c ? hi : 8'h00);
      wr(0, 8'h0c | 8'(c));
      pins.strike(1'b1, 1);
      wr(0, 8'h00);
      bus(c ? 32'h0000_0010 : 32'h0000_0008, 1'b0, 8'h00, hi);
    end
    $display("trigger done");
    for (int b = 4; b < 6; b++) begin
      hi = 8'($urandom);
      wr(3, 8'h00); wr(4, hi); wr(1, 8'hf0); wr(2, 8'hff);
      t0 = ticks;
      wr(0, (8'h01 << b) | 8'h05);
      waitHigh(1'b1);
      bus(32'h0000_0008, 1'b0, 8'h00, hi);
      wr(0, 8'h00);
      check("baud ticks", 16'(t0 + 1), 16'(ticks));
    end
    $display("baud done");
    n = 1 + $urandom % 5;
    wr(1, 8'h00); wr(2, 8'h00);
    wr(0, 8'h06);
    pins.strike(1'b0, n);
    wr(0, 8'h00);
    repeat (10) @(posedge clk);
    bus(32'h0000_0004, 1'b0, 8'h00, 8'(n));
    $display("counter done");
    wrap_up();
  end
endmodule // timer_mode_control_tb_top
